// ===== hdl/ssp_pkg.sv
// Constants for the sensorless switchover parameter block
package ssp_pkg;
    localparam int DATA_W = 32;
    localparam int SUB_W = 8;

    // ------------------------------------------------------------
    // Entry subindices
    // ------------------------------------------------------------
    localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] SUB_RESISTANCE = 8'h01;
    localparam logic [7:0] SUB_INDUCTANCE = 8'h02;
    localparam logic [7:0] SUB_FLUX = 8'h03;
    localparam logic [7:0] SUB_ON_SPEED = 8'h04;
    localparam logic [7:0] SUB_OFF_SPEED = 8'h05;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENTRY_COUNT = 8'h05;
    localparam logic [31:0] RST_RESISTANCE = 32'h0000_0000;
    localparam logic [31:0] RST_INDUCTANCE = 32'h0000_0000;
    localparam logic [31:0] RST_FLUX = 32'h0000_0000;
    localparam logic [31:0] RST_ON_SPEED = 32'h0000_0078;
    localparam logic [31:0] RST_OFF_SPEED = 32'h0000_0064;

    // Entry access answer latency, in core_clk cycles
    localparam int ACK_LATENCY = 1;
endpackage

// ===== hdl/ssp_thr_if.sv
// Carrier between the parameter store and the switchover comparator
interface ssp_thr_if;
    logic [31:0] on_speed;
    logic [31:0] off_speed;
    logic [31:0] speed;
    logic sensors_absent;
    logic enable;

    modport store (
        output on_speed,
        output off_speed,
        output speed,
        output sensors_absent,
        input enable
    );
    modport cmp (
        input on_speed,
        input off_speed,
        input speed,
        input sensors_absent,
        output enable
    );
endinterface

// ===== hdl/ssp_switch.sv
// Hysteresis comparator deciding sensorless closed-loop enable
module ssp_switch (
    input wire logic core_clk,
    input wire logic resetn,
    ssp_thr_if.cmp thr
);
    logic enable;
    logic next_enable;
    wire above_on = thr.speed > thr.on_speed;
    wire below_off = thr.speed < thr.off_speed;

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    // Off wins if thresholds are crossed, so a bad setting fails safe
    always_comb begin
        next_enable = enable; // R7
        if (!thr.sensors_absent) begin
            next_enable = 1'b0;
        end else if (below_off) begin
            next_enable = 1'b0; // R6
        end else if (above_on) begin
            next_enable = 1'b1; // R5
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            enable <= 1'b0;
        end else begin
            enable <= next_enable;
        end
    end

    assign thr.enable = enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_switch_on;
        @(posedge core_clk) disable iff (!resetn)
        (thr.sensors_absent && above_on && !below_off) |=> enable;
    endproperty
    a_switch_on: assert property (p_switch_on) // R5
        else $error("sensorless not enabled above switch-on speed");

    property p_switch_off;
        @(posedge core_clk) disable iff (!resetn)
        (below_off || !thr.sensors_absent) |=> !enable;
    endproperty
    a_switch_off: assert property (p_switch_off) // R6
        else $error("sensorless not disabled below switch-off speed");

    property p_hold;
        @(posedge core_clk) disable iff (!resetn)
        (thr.sensors_absent && !above_on && !below_off)
            |=> (enable == $past(enable));
    endproperty
    a_hold: assert property (p_hold) // R7
        else $error("sensorless enable changed inside hysteresis band");
endmodule

// ===== hdl/ssp_top.sv
// Sensorless motor parameter store and switchover control
//
// Summary of operation
// R1 - One parameter set feeds both sensorless control and field weakening.
// R2 - Winding resistance held as 32-bit float pattern, loaded by auto setup.
// R3 - Winding inductance held as 32-bit float pattern, loaded by auto setup.
// R4 - Interlinking flux held as 32-bit float pattern, loaded by auto setup.
// R5 - Without sensors, enable sensorless above switch-on speed, default 0x78.
// R6 - Without sensors, disable sensorless below switch-off speed, default 0x64.
// R7 - Between the thresholds the sensorless enable state is held.
module ssp_top (
    input wire logic core_clk,
    input wire logic resetn,
    // Entry access by subindex
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [7:0] od_subindex,
    input wire logic [31:0] od_wdata,
    output logic od_ack,
    output logic od_abort,
    output logic [31:0] od_rdata,
    // Auto setup results
    input wire logic setup_load,
    input wire logic setup_sensors_found,
    input wire logic [31:0] setup_resistance,
    input wire logic [31:0] setup_inductance,
    input wire logic [31:0] setup_flux,
    // Motor speed magnitude in rpm
    input wire logic [31:0] motor_speed,
    // Parameter set for the control loops
    output logic [31:0] foc_resistance,
    output logic [31:0] foc_inductance,
    output logic [31:0] foc_flux,
    output logic [31:0] fw_resistance,
    output logic [31:0] fw_inductance,
    output logic [31:0] fw_flux,
    output logic sensors_absent,
    output logic sensorless_enable
);
    logic [31:0] winding_resistance;
    logic [31:0] winding_inductance;
    logic [31:0] interlinking_flux;
    logic [31:0] sensorless_on_speed;
    logic [31:0] sensorless_off_speed;
    logic absent;
    logic ack;
    logic abort;
    logic [31:0] rdata;

    // ------------------------------------------------------------
    // Subindex decode
    // ------------------------------------------------------------
    wire hit_count = od_subindex == ssp_pkg::SUB_ENTRY_COUNT;
    wire hit_res = od_subindex == ssp_pkg::SUB_RESISTANCE;
    wire hit_ind = od_subindex == ssp_pkg::SUB_INDUCTANCE;
    wire hit_flux = od_subindex == ssp_pkg::SUB_FLUX;
    wire hit_on = od_subindex == ssp_pkg::SUB_ON_SPEED;
    wire hit_off = od_subindex == ssp_pkg::SUB_OFF_SPEED;
    wire hit_rw = hit_res | hit_ind | hit_flux | hit_on | hit_off;
    wire hit_any = hit_rw | hit_count;
    wire bad_access = !hit_any || (od_write && hit_count);
    wire wr_ok = od_req && od_write && hit_rw;
    wire rd_ok = od_req && !od_write && hit_any;

    wire [31:0] read_mux =
        hit_count ? {24'h00_0000, ssp_pkg::RST_ENTRY_COUNT} :
        hit_res ? winding_resistance :
        hit_ind ? winding_inductance :
        hit_flux ? interlinking_flux :
        hit_on ? sensorless_on_speed :
        hit_off ? sensorless_off_speed : 32'h0000_0000;

    // ------------------------------------------------------------
    // Motor model parameters
    // ------------------------------------------------------------
    // Auto setup wins over a master write in the same cycle: the
    // measured value is the one the loops must run with.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            winding_resistance <= ssp_pkg::RST_RESISTANCE;
            winding_inductance <= ssp_pkg::RST_INDUCTANCE;
            interlinking_flux <= ssp_pkg::RST_FLUX;
        end else if (setup_load) begin
            winding_resistance <= setup_resistance; // R2
            winding_inductance <= setup_inductance; // R3
            interlinking_flux <= setup_flux; // R4
        end else if (wr_ok) begin
            if (hit_res) begin
                winding_resistance <= od_wdata; // R2
            end
            if (hit_ind) begin
                winding_inductance <= od_wdata; // R3
            end
            if (hit_flux) begin
                interlinking_flux <= od_wdata; // R4
            end
        end
    end

    // ------------------------------------------------------------
    // Switchover thresholds and sensor presence
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sensorless_on_speed <= ssp_pkg::RST_ON_SPEED;
            sensorless_off_speed <= ssp_pkg::RST_OFF_SPEED;
        end else if (wr_ok && hit_on) begin
            sensorless_on_speed <= od_wdata; // R5
        end else if (wr_ok && hit_off) begin
            sensorless_off_speed <= od_wdata; // R6
        end
    end

    // Sensors assumed present until setup says otherwise: safe default
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            absent <= 1'b0;
        end else if (setup_load) begin
            absent <= !setup_sensors_found;
        end
    end

    // ------------------------------------------------------------
    // Access answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack <= 1'b0;
            abort <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= od_req && !bad_access;
            abort <= od_req && bad_access;
            rdata <= rd_ok ? read_mux : 32'h0000_0000;
        end
    end

    assign od_ack = ack;
    assign od_abort = abort;
    assign od_rdata = rdata;

    // ------------------------------------------------------------
    // Outputs to both control loops
    // ------------------------------------------------------------
    assign foc_resistance = winding_resistance; // R1
    assign foc_inductance = winding_inductance; // R1
    assign foc_flux = interlinking_flux; // R1
    assign fw_resistance = winding_resistance; // R1
    assign fw_inductance = winding_inductance; // R1
    assign fw_flux = interlinking_flux; // R1
    assign sensors_absent = absent;

    ssp_thr_if thr ();
    assign thr.on_speed = sensorless_on_speed;
    assign thr.off_speed = sensorless_off_speed;
    assign thr.speed = motor_speed;
    assign thr.sensors_absent = absent;
    assign sensorless_enable = thr.enable;

    ssp_switch u_switch (
        .core_clk(core_clk),
        .resetn(resetn),
        .thr(thr)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_same_set;
        @(posedge core_clk) disable iff (!resetn)
        (fw_resistance == foc_resistance) && (fw_flux == foc_flux)
            && (fw_inductance == foc_inductance);
    endproperty
    a_same_set: assert property (p_same_set) // R1
        else $error("loops see different parameter sets");

    property p_res_load;
        @(posedge core_clk) disable iff (!resetn)
        setup_load |=> foc_resistance == $past(setup_resistance);
    endproperty
    a_res_load: assert property (p_res_load) // R2
        else $error("resistance not taken from auto setup");

    property p_ind_load;
        @(posedge core_clk) disable iff (!resetn)
        setup_load |=> foc_inductance == $past(setup_inductance);
    endproperty
    a_ind_load: assert property (p_ind_load) // R3
        else $error("inductance not taken from auto setup");

    sequence s_flux_write;
        od_req && od_write && hit_flux && !setup_load;
    endsequence
    // One idle cycle, the gap a master leaves between two accesses
    sequence s_flux_quiet;
        !setup_load && !(od_req && od_write && hit_flux);
    endsequence
    sequence s_flux_read;
        od_req && !od_write && hit_flux && !setup_load;
    endsequence
    property p_flux_roundtrip;
        @(posedge core_clk) disable iff (!resetn)
        s_flux_write ##1 s_flux_quiet ##1 s_flux_read
            |=> od_ack && od_rdata == $past(od_wdata, 3);
    endproperty
    a_flux_roundtrip: assert property (p_flux_roundtrip) // R4
        else $error("flux write not read back");

    property p_thresholds;
        @(posedge core_clk) disable iff (!resetn)
        (od_req && od_write && hit_on) |=> thr.on_speed == $past(od_wdata);
    endproperty
    a_thresholds: assert property (p_thresholds) // R5
        else $error("switch-on speed write lost");
endmodule

// ===== dv/ssp_master_model.sv
// Fieldbus master model issuing subindex entry accesses
module ssp_master_model (
    input wire logic core_clk,
    output logic od_req,
    output logic od_write,
    output logic [7:0] od_subindex,
    output logic [31:0] od_wdata,
    input wire logic od_ack,
    input wire logic od_abort,
    input wire logic [31:0] od_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        od_req = 1'b0;
        od_write = 1'b0;
        od_subindex = 8'h00;
        od_wdata = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // One request pulse, answer sampled one edge later
    // ------------------------------------------------------------
    task automatic access(input logic w, input logic [7:0] sub,
        input logic [31:0] wd, output logic ack, output logic abt,
        output logic [31:0] rd);
        @(posedge core_clk);
        #1;
        od_req = 1'b1;
        od_write = w;
        od_subindex = sub;
        od_wdata = wd;
        @(posedge core_clk);
        #1;
        ack = od_ack;
        abt = od_abort;
        rd = od_rdata;
        od_req = 1'b0;
        // Released lines must not keep looking valid
        od_write = ~w;
        od_subindex = ~sub;
        od_wdata = ~wd;
    endtask
endmodule

// ===== dv/sensorless_switchover_params_tb.sv
// Self-checking bench for the sensorless switchover parameter block
module sensorless_switchover_params_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic resetn;
    logic od_req, od_write, od_ack, od_abort;
    logic [7:0] od_subindex;
    logic [31:0] od_wdata, od_rdata;
    logic setup_load, setup_sensors_found;
    logic [31:0] setup_resistance, setup_inductance, setup_flux;
    logic [31:0] motor_speed;
    logic [31:0] foc_resistance, foc_inductance, foc_flux;
    logic [31:0] fw_resistance, fw_inductance, fw_flux;
    logic sensors_absent, sensorless_enable;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    logic a, b;
    logic [31:0] r;
    logic [31:0] rv [6] = '{32'h5, 32'h0, 32'h0, 32'h0, 32'h78, 32'h64};
    logic [31:0] sp [13] = '{32'h79, 32'h78, 32'h64, 32'h63, 32'h64,
        32'h78, 32'h79, 32'h1ff, 32'h201, 32'h100, 32'hff, 32'h101,
        32'h201};
    logic ex [13] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
        1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    ssp_top DUT (.core_clk(core_clk), .resetn(resetn), .od_req(od_req),
        .od_write(od_write), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
        .od_rdata(od_rdata), .setup_load(setup_load),
        .setup_sensors_found(setup_sensors_found),
        .setup_resistance(setup_resistance),
        .setup_inductance(setup_inductance), .setup_flux(setup_flux),
        .motor_speed(motor_speed), .foc_resistance(foc_resistance),
        .foc_inductance(foc_inductance), .foc_flux(foc_flux),
        .fw_resistance(fw_resistance), .fw_inductance(fw_inductance),
        .fw_flux(fw_flux), .sensors_absent(sensors_absent),
        .sensorless_enable(sensorless_enable));

    ssp_master_model master (.core_clk(core_clk), .od_req(od_req),
        .od_write(od_write), .od_subindex(od_subindex),
        .od_wdata(od_wdata), .od_ack(od_ack), .od_abort(od_abort),
        .od_rdata(od_rdata));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] s,
        input logic [31:0] wd, input logic ab, input logic [31:0] er);
        master.access(w, s, wd, a, b, r);
        chk("od_ack", {31'h0, ~ab}, {31'h0, a});
        chk("od_abort", {31'h0, ab}, {31'h0, b});
        chk("od_rdata", er, r);
    endtask

    // Both loops must see one and the same set
    task automatic par(input logic [31:0] er, input logic [31:0] el,
        input logic [31:0] ef);
        chk("foc_resistance", er, foc_resistance);
        chk("foc_inductance", el, foc_inductance);
        chk("foc_flux", ef, foc_flux);
        chk("fw_resistance", er, fw_resistance);
        chk("fw_inductance", el, fw_inductance);
        chk("fw_flux", ef, fw_flux);
    endtask

    task automatic spd(input logic [31:0] v, input logic e);
        motor_speed = v;
        @(posedge core_clk);
        #1;
        chk("sensorless_enable", {31'h0, e}, {31'h0, sensorless_enable});
    endtask

    task automatic load(input logic found);
        setup_sensors_found = found;
        setup_load = 1'b1;
        @(posedge core_clk);
        #1;
        setup_load = 1'b0;
        chk("sensors_absent", {31'h0, ~found}, {31'h0, sensors_absent});
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard, far above the some 60 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        setup_load = 1'b0;
        setup_sensors_found = 1'b1;
        setup_resistance = 32'h3f20_0000;
        setup_inductance = 32'h3a83_126f;
        setup_flux = 32'h3c23_d70a;
        motor_speed = 32'h0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        par(32'h0, 32'h0, 32'h0);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, i[7:0], 32'h0, 1'b0, rv[i]);
        end
        acc(1'b1, 8'h00, 32'h7, 1'b1, 32'h0);
        acc(1'b0, 8'h06, 32'h0, 1'b1, 32'h0);
        acc(1'b1, 8'hff, 32'h1, 1'b1, 32'h0);
        acc(1'b0, 8'h00, 32'h0, 1'b0, 32'h5);
        acc(1'b1, 8'h01, 32'h3f80_0000, 1'b0, 32'h0);
        acc(1'b1, 8'h02, 32'h3b44_9ba6, 1'b0, 32'h0);
        acc(1'b1, 8'h03, 32'hbd4c_cccd, 1'b0, 32'h0);
        par(32'h3f80_0000, 32'h3b44_9ba6, 32'hbd4c_cccd);
        acc(1'b0, 8'h03, 32'h0, 1'b0, 32'hbd4c_cccd);
        spd(32'h1000, 1'b0);
        spd(32'h0, 1'b0);
        load(1'b0);
        par(32'h3f20_0000, 32'h3a83_126f, 32'h3c23_d70a);
        acc(1'b0, 8'h02, 32'h0, 1'b0, 32'h3a83_126f);
        for (int i = 0; i < 7; i++) begin
            spd(sp[i], ex[i]);
        end
        acc(1'b1, 8'h04, 32'h200, 1'b0, 32'h0);
        acc(1'b1, 8'h05, 32'h100, 1'b0, 32'h0);
        acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h200);
        for (int i = 7; i < 13; i++) begin
            spd(sp[i], ex[i]);
        end
        load(1'b1);
        spd(32'h201, 1'b0);
        resetn = 1'b0;
        @(posedge core_clk);
        #1;
        resetn = 1'b1;
        chk("sensorless_enable", 32'h0, {31'h0, sensorless_enable});
        acc(1'b0, 8'h04, 32'h0, 1'b0, 32'h78);
        acc(1'b0, 8'h01, 32'h0, 1'b0, 32'h0);
        close_out();
    end
endmodule
